// file: logic/ram_block_pkg.sv
`default_nettype none
package ram_block_pkg;

   localparam int WORD_BITS = 36;
   localparam int WORDS     = 512;
   localparam int WIDX_W    = 9;
   localparam int ADDR_W    = 14;
   localparam int OFF_W     = 15;
   localparam int LANE_W    = 6;
   localparam int BYTES     = 4;
   localparam int BYTE_BITS = 9;
   localparam int PAR_POS   = 8;
   localparam int HI_W      = 4;
   localparam int APB_AW    = 8;

   localparam logic [APB_AW-1:0] CTRL_OFS      = 8'h00;
   localparam logic [APB_AW-1:0] STATUS_OFS    = 8'h04;
   localparam logic [APB_AW-1:0] INIT_ADDR_OFS = 8'h08;
   localparam logic [APB_AW-1:0] INIT_DATA_OFS = 8'h0C;
   localparam logic [APB_AW-1:0] INIT_HI_OFS   = 8'h10;

   localparam int CTRL_W      = 17;
   localparam int CTRL_MODE   = 0;
   localparam int CTRL_WA     = 2;
   localparam int CTRL_WB     = 5;
   localparam int CTRL_WMA    = 8;
   localparam int CTRL_WMB    = 10;
   localparam int CTRL_OREGA  = 12;
   localparam int CTRL_OREGB  = 13;
   localparam int CTRL_PAR    = 14;
   localparam int CTRL_SYNCA  = 15;
   localparam int CTRL_SYNCB  = 16;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 17'h00000;

   localparam int ST_TDP36 = 0;
   localparam int ST_RBW   = 1;
   localparam int ST_COLL  = 2;

   typedef enum logic [1:0] {
      MODE_SP  = 2'b00,
      MODE_TDP = 2'b01,
      MODE_PDP = 2'b10,
      MODE_ROM = 2'b11
   } ram_mode_t;

   typedef enum logic [1:0] {
      WR_NORMAL     = 2'b00,
      WR_THROUGH    = 2'b01,
      WR_READ_FIRST = 2'b10
   } write_mode_t;

   typedef enum logic [2:0] {
      W1  = 3'h0,
      W2  = 3'h1,
      W4  = 3'h2,
      W9  = 3'h3,
      W18 = 3'h4,
      W36 = 3'h5
   } port_width_t;

   function automatic logic [5:0] widthBits(port_width_t w);
      case (w)
         W1:      return 6'h01;
         W2:      return 6'h02;
         W4:      return 6'h04;
         W9:      return 6'h09;
         W18:     return 6'h12;
         default: return 6'h24;
      endcase
   endfunction

   function automatic logic [3:0] addrBits(port_width_t w);
      case (w)
         W1:      return 4'hE;
         W2:      return 4'hD;
         W4:      return 4'hC;
         W9:      return 4'hB;
         W18:     return 4'hA;
         default: return 4'h9;
      endcase
   endfunction

endpackage
`default_nettype wire

// file: logic/ram_port_unit.sv
`timescale 1ns/1ps
`default_nettype none
module ram_port_unit
   import ram_block_pkg::*;
(
   input  wire logic                 mclk,     // clock
   input  wire logic                 nrst,     // async reset, low
   input  wire logic                 clrN,     // async output clear, low
   input  wire logic                 syncClr,  // sync output clear
   input  wire port_width_t          width,    // port width
   input  wire write_mode_t          wmode,    // write behaviour
   input  wire logic                 outReg,   // output register on
   input  wire logic                 parityEn, // keep parity bits
   input  wire logic                 ce,       // port enable
   input  wire logic                 we,       // write request
   input  wire logic [ADDR_W-1:0]    addr,     // word address
   input  wire logic [WORD_BITS-1:0] din,      // write data
   input  wire logic [BYTES-1:0]     be,       // byte enables
   input  wire logic [WORD_BITS-1:0] rdWord,   // array word
   output logic [WIDX_W-1:0]         wordIdx,  // array word index
   output logic [WORD_BITS-1:0]      accMask,  // bits touched
   output logic [WORD_BITS-1:0]      wrMask,   // bits written
   output logic [WORD_BITS-1:0]      wrBits,   // data placed in word
   output logic                      wrFire,   // write this cycle
   output logic                      accOn,    // access this cycle
   output logic [WORD_BITS-1:0]      dout      // read data
);

   logic [ADDR_W-1:0]    addrReg;
   logic [WORD_BITS-1:0] dinReg;
   logic [BYTES-1:0]     beReg;
   logic                 weReg;
   logic                 ceReg;
   logic [WORD_BITS-1:0] latchReg;
   logic [ADDR_W-1:0]    addrUse;
   logic [OFF_W-1:0]     bitOff;
   logic [LANE_W-1:0]    lane;
   logic [5:0]           nBits;
   logic                 byteWide;
   logic [WORD_BITS-1:0] fieldMask;
   logic [WORD_BITS-1:0] beMask;
   logic [WORD_BITS-1:0] parMask;
   logic [WORD_BITS-1:0] dataIn;
   logic [WORD_BITS-1:0] oldField;
   logic [WORD_BITS-1:0] readField;
   logic [WORD_BITS-1:0] mergeField;
   logic [WORD_BITS-1:0] latchNext;

   // inputs hold while the port is disabled
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         addrReg <= '0;
         dinReg  <= '0;
         beReg   <= '0;
         weReg   <= 1'b0;
      end
      else if (ce)
      begin
         addrReg <= addr;
         dinReg  <= din;
         beReg   <= be;
         weReg   <= we;
      end
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         ceReg <= 1'b0;
      else
         ceReg <= ce;
   end

   always_comb
   begin
      nBits = widthBits(width);
      // upper address bits beyond the depth are dropped
      addrUse = addrReg & ADDR_W'((15'h1 << addrBits(width)) - 15'h1);
      bitOff = OFF_W'({1'b0, addrUse} * OFF_W'(nBits));
      wordIdx = WIDX_W'(bitOff / OFF_W'(WORD_BITS));
      lane = LANE_W'(bitOff % OFF_W'(WORD_BITS));
      // a full-width shift wraps to zero, so x36 yields all ones
      fieldMask = (WORD_BITS'(1) << nBits) - WORD_BITS'(1);
      byteWide = (width == W18) || (width == W36);
      beMask = '1;
      parMask = '1;
      for (int k = 0; k < BYTES; k++)
      begin
         if (byteWide && !beReg[k])
            beMask[k*BYTE_BITS +: BYTE_BITS] = '0;
         if (!parityEn && nBits >= 6'(BYTE_BITS))
            parMask[k*BYTE_BITS+PAR_POS] = 1'b0;
      end
      dataIn = dinReg & fieldMask & beMask & parMask;
      oldField = (rdWord >> lane) & fieldMask;
      readField = oldField & parMask;
      mergeField = (readField & ~beMask) | dataIn;
      accMask = fieldMask << lane;
      wrMask = (fieldMask & beMask) << lane;
      wrBits = dataIn << lane;
      wrFire = ceReg && weReg;
      accOn = ceReg;
      latchNext = latchReg;
      if (ceReg)
      begin
         if (!weReg)
            latchNext = readField;
         else
            unique case (wmode)
               WR_NORMAL:     latchNext = latchReg;
               WR_THROUGH:    latchNext = mergeField;
               WR_READ_FIRST: latchNext = readField;
               default:       latchNext = latchReg;
            endcase
      end
   end

   always_ff @(posedge mclk or negedge clrN)
   begin
      if (!clrN)
         latchReg <= '0;
      else if (syncClr)
         latchReg <= '0;
      else
         latchReg <= latchNext;
   end

   always_ff @(posedge mclk or negedge clrN)
   begin
      if (!clrN)
         dout <= '0;
      else if (syncClr)
         dout <= '0;
      else if (!outReg)
         dout <= latchNext;
      else if (ce)
         dout <= latchReg;
   end

   AST_OUT_DIRECT: assert property (@(posedge mclk) disable iff (!clrN)
      (ceReg && !weReg && !outReg && !syncClr) |=> (dout == $past(readField)))
      else $error("direct read data not on output next cycle");

   AST_OUT_PIPED: assert property (@(posedge mclk) disable iff (!clrN)
      (ceReg && !weReg && outReg && !syncClr) ##1 (outReg && ce && !syncClr)
      |=> (dout == $past(readField, 2)))
      else $error("registered read data not on output two cycles on");

   AST_NORMAL_HOLD: assert property (@(posedge mclk) disable iff (!clrN)
      (wrFire && wmode == WR_NORMAL && !syncClr) |=> $stable(latchReg))
      else $error("normal write changed the output latch");

   AST_THROUGH: assert property (@(posedge mclk) disable iff (!clrN)
      (wrFire && wmode == WR_THROUGH && !syncClr)
      |=> (latchReg == ($past(dataIn) | ($past(readField) & ~$past(beMask)))))
      else $error("write-through did not show written data");

   AST_READ_FIRST: assert property (@(posedge mclk) disable iff (!clrN)
      (wrFire && wmode == WR_READ_FIRST && !syncClr)
      |=> (latchReg == (($past(rdWord) >> $past(lane)) & $past(fieldMask)
         & $past(parMask))))
      else $error("read-before-write did not show old data");

   AST_SYNC_CLR: assert property (@(posedge mclk) disable iff (!clrN)
      syncClr |=> (latchReg == '0 && dout == '0))
      else $error("synchronous output reset did not clear");

   AST_BYTE_EN: assert property (@(posedge mclk) disable iff (!nrst)
      (wrFire && byteWide && !beReg[1])
      |-> (((wrMask >> lane) & WORD_BITS'(36'h3FE00)) == '0))
      else $error("disabled byte still written");

endmodule
`default_nettype wire

// file: logic/embedded_ram_block.sv
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module embedded_ram_block
   import ram_block_pkg::*;
(
   input  wire logic                 mclk,             // clock, 250 MHz
   input  wire logic                 nrst,             // async reset, low
   input  wire logic                 globalSetResetN,  // clears both outputs
   input  wire logic [APB_AW-1:0]    paddr,            // apb address
   input  wire logic                 psel,             // apb select
   input  wire logic                 penable,          // apb enable
   input  wire logic                 pwrite,           // apb direction
   input  wire logic [31:0]          pwdata,           // apb write data
   output logic [31:0]               prdata,           // apb read data
   output logic                      pready,           // apb ready
   output logic                      pslverr,          // apb error
   input  wire logic                 ceA,              // port a enable
   input  wire logic                 weA,              // port a write
   input  wire logic [ADDR_W-1:0]    addrA,            // port a address
   input  wire logic [WORD_BITS-1:0] dinA,             // port a data in
   input  wire logic [BYTES-1:0]     beA,              // port a byte en
   input  wire logic                 portAOutputReset, // port a out clear
   output logic [WORD_BITS-1:0]      doutA,            // port a data out
   input  wire logic                 ceB,              // port b enable
   input  wire logic                 weB,              // port b write
   input  wire logic [ADDR_W-1:0]    addrB,            // port b address
   input  wire logic [WORD_BITS-1:0] dinB,             // port b data in
   input  wire logic [BYTES-1:0]     beB,              // port b byte en
   input  wire logic                 portBOutputReset, // port b out clear
   output logic [WORD_BITS-1:0]      doutB             // port b data out
);

   logic [WORD_BITS-1:0] mem [WORDS];

   logic [CTRL_W-1:0]    ctrlReg;
   logic                 collReg;
   logic [WIDX_W-1:0]    initAddrReg;
   logic [HI_W-1:0]      initHiReg;
   ram_mode_t            mode;
   port_width_t          rawWA;
   port_width_t          rawWB;
   port_width_t          widthA;
   port_width_t          widthB;
   write_mode_t          wmodeA;
   write_mode_t          wmodeB;
   logic                 tdpErr;
   logic                 rbwErr;
   logic                 allowA;
   logic                 allowB;
   logic                 ceBEff;
   logic                 syncA;
   logic                 syncB;
   logic                 clrNA;
   logic                 clrNB;
   logic [WIDX_W-1:0]    wordA;
   logic [WIDX_W-1:0]    wordB;
   logic [WORD_BITS-1:0] accMaskA;
   logic [WORD_BITS-1:0] accMaskB;
   logic [WORD_BITS-1:0] maskA;
   logic [WORD_BITS-1:0] maskB;
   logic [WORD_BITS-1:0] bitsA;
   logic [WORD_BITS-1:0] bitsB;
   logic                 fireA;
   logic                 fireB;
   logic                 accOnA;
   logic                 accOnB;
   logic [WORD_BITS-1:0] mergeA;
   logic [WORD_BITS-1:0] baseB;
   logic [WORD_BITS-1:0] mergeB;
   logic                 collNow;
   logic                 setup;
   logic                 access;
   logic                 mapped;
   logic [31:0]          rdMux;
   logic                 initWr;

   function automatic port_width_t fixWidth(logic [2:0] code, logic tdp);
      port_width_t w;
      w = (code > 3'(W36)) ? W36 : port_width_t'(code);
      // true dual-port cannot reach x36, so fall back to x18
      if (tdp && w == W36)
         w = W18;
      return w;
   endfunction

   function automatic write_mode_t fixMode(logic [1:0] code,
                                           port_width_t w);
      write_mode_t m;
      m = (code == 2'(WR_READ_FIRST) || code == 2'(WR_THROUGH)) ?
          write_mode_t'(code) : WR_NORMAL;
      // read-before-write only exists from x9 upward
      if (m == WR_READ_FIRST && w < W9)
         m = WR_NORMAL;
      return m;
   endfunction

   // configuration decode: each port has its own width and mode
   always_comb
   begin
      mode = ram_mode_t'(ctrlReg[CTRL_MODE +: 2]);
      rawWA = port_width_t'(ctrlReg[CTRL_WA +: 3]);
      rawWB = port_width_t'(ctrlReg[CTRL_WB +: 3]);
      widthA = fixWidth(ctrlReg[CTRL_WA +: 3], mode == MODE_TDP);
      widthB = fixWidth(ctrlReg[CTRL_WB +: 3], mode == MODE_TDP);
      wmodeA = fixMode(ctrlReg[CTRL_WMA +: 2], widthA);
      wmodeB = fixMode(ctrlReg[CTRL_WMB +: 2], widthB);
      tdpErr = (mode == MODE_TDP) && (rawWA >= W36 || rawWB >= W36);
      rbwErr = (ctrlReg[CTRL_WMA +: 2] == 2'(WR_READ_FIRST) && widthA < W9)
            || (ctrlReg[CTRL_WMB +: 2] == 2'(WR_READ_FIRST) && widthB < W9);
      allowA = (mode != MODE_ROM);
      allowB = (mode == MODE_TDP);
      ceBEff = ceB && (mode != MODE_SP);
      syncA = ctrlReg[CTRL_SYNCA];
      syncB = ctrlReg[CTRL_SYNCB];
   end

   // a port reset picked as asynchronous acts at once, the other waits
   assign clrNA = nrst && globalSetResetN && !(portAOutputReset && !syncA);
   assign clrNB = nrst && globalSetResetN && !(portBOutputReset && !syncB);

   ram_port_unit portA (
      .mclk     (mclk),
      .nrst     (nrst),
      .clrN     (clrNA),
      .syncClr  (portAOutputReset && syncA),
      .width    (widthA),
      .wmode    (wmodeA),
      .outReg   (ctrlReg[CTRL_OREGA]),
      .parityEn (ctrlReg[CTRL_PAR]),
      .ce       (ceA),
      .we       (weA && allowA),
      .addr     (addrA),
      .din      (dinA),
      .be       (beA),
      .rdWord   (mem[wordA]),
      .wordIdx  (wordA),
      .accMask  (accMaskA),
      .wrMask   (maskA),
      .wrBits   (bitsA),
      .wrFire   (fireA),
      .accOn    (accOnA),
      .dout     (doutA)
   );

   ram_port_unit portB (
      .mclk     (mclk),
      .nrst     (nrst),
      .clrN     (clrNB),
      .syncClr  (portBOutputReset && syncB),
      .width    (widthB),
      .wmode    (wmodeB),
      .outReg   (ctrlReg[CTRL_OREGB]),
      .parityEn (ctrlReg[CTRL_PAR]),
      .ce       (ceBEff),
      .we       (weB && allowB),
      .addr     (addrB),
      .din      (dinB),
      .be       (beB),
      .rdWord   (mem[wordB]),
      .wordIdx  (wordB),
      .accMask  (accMaskB),
      .wrMask   (maskB),
      .wrBits   (bitsB),
      .wrFire   (fireB),
      .accOn    (accOnB),
      .dout     (doutB)
   );

   // two narrow words can share one array word, so b merges on top of a
   always_comb
   begin
      mergeA = (mem[wordA] & ~maskA) | (bitsA & maskA);
      baseB = (fireA && wordA == wordB) ? mergeA : mem[wordB];
      mergeB = (baseB & ~maskB) | (bitsB & maskB);
      collNow = ((fireA && accOnB) || (fireB && accOnA))
             && (wordA == wordB) && ((accMaskA & accMaskB) != '0);
   end

   // array has no reset; preload happens through the init registers
   always_ff @(posedge mclk)
   begin
      if (initWr)
         mem[initAddrReg] <= {initHiReg, pwdata};
      if (fireA)
         mem[wordA] <= mergeA;
      if (fireB)
         mem[wordB] <= mergeB;
   end

   assign setup = psel && !penable;
   assign access = psel && penable && pready;
   assign initWr = access && pwrite && paddr == INIT_DATA_OFS;

   always_comb
   begin
      mapped = 1'b1;
      rdMux = '0;
      case (paddr)
         CTRL_OFS:      rdMux = 32'(ctrlReg);
         STATUS_OFS:
         begin
            rdMux[ST_TDP36] = tdpErr;
            rdMux[ST_RBW] = rbwErr;
            rdMux[ST_COLL] = collReg;
         end
         INIT_ADDR_OFS: rdMux = 32'(initAddrReg);
         INIT_DATA_OFS: rdMux = '0;
         INIT_HI_OFS:   rdMux = 32'(initHiReg);
         default:       mapped = 1'b0;
      endcase
   end

   // one cycle after setup the answer is ready: no further wait states
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end
      else
      begin
         pready <= setup;
         pslverr <= setup && !mapped;
         prdata <= (setup && !pwrite) ? rdMux : 32'h0000_0000;
      end
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         ctrlReg <= CTRL_RESET;
      else if (access && pwrite && paddr == CTRL_OFS)
         ctrlReg <= pwdata[CTRL_W-1:0];
   end

   // a conflict in the clearing cycle survives the clear
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         collReg <= 1'b0;
      else
         collReg <= collNow || (collReg && !(access && pwrite
                    && paddr == STATUS_OFS && pwdata[ST_COLL]));
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         initAddrReg <= '0;
         initHiReg <= '0;
      end
      else if (access && pwrite)
      begin
         if (paddr == INIT_ADDR_OFS)
            initAddrReg <= pwdata[WIDX_W-1:0];
         else if (paddr == INIT_HI_OFS)
            initHiReg <= pwdata[HI_W-1:0];
         else if (paddr == INIT_DATA_OFS)
            initAddrReg <= initAddrReg + WIDX_W'(1);
      end
   end

   AST_ROM_LOCK: assert property (@(posedge mclk) disable iff (!nrst)
      (mode == MODE_ROM) ##1 (mode == MODE_ROM) |-> !(fireA || fireB))
      else $error("write reached the array in read-only mode");

   AST_TDP_CLAMP: assert property (@(posedge mclk) disable iff (!nrst)
      (mode == MODE_TDP) |-> (widthA != W36 && widthB != W36))
      else $error("true dual-port running at x36");

   AST_WRITE_LAND: assert property (@(posedge mclk) disable iff (!nrst)
      (ceA && weA && allowA) |=> fireA)
      else $error("registered write did not reach the array");

   AST_SP_PORTB: assert property (@(posedge mclk) disable iff (!nrst)
      (mode == MODE_SP) |=> !accOnB)
      else $error("port b active in single-port mode");

   AST_COLL_STICKY: assert property (@(posedge mclk) disable iff (!nrst)
      collNow |=> collReg)
      else $error("port conflict not held in status");

   AST_CTRL_LOAD: assert property (@(posedge mclk) disable iff (!nrst)
      (access && pwrite && paddr == CTRL_OFS)
      |=> (ctrlReg == CTRL_W'($past(pwdata))))
      else $error("configuration write not taken");

   AST_PDP_READ_B: assert property (@(posedge mclk) disable iff (!nrst)
      (mode == MODE_PDP) ##1 (mode == MODE_PDP) |-> !fireB)
      else $error("port b wrote in pseudo dual-port mode");

   AST_INIT_STEP: assert property (@(posedge mclk) disable iff (!nrst)
      initWr |=> (initAddrReg == $past(initAddrReg) + WIDX_W'(1)))
      else $error("preload address did not advance");

   AST_ACLR_A: assert property (@(posedge mclk) disable iff (!nrst)
      (portAOutputReset && !syncA) |-> (doutA == '0))
      else $error("asynchronous port a reset did not clear");

   AST_ALL_CLR: assert property (@(posedge mclk) disable iff (!nrst)
      !globalSetResetN |-> (doutA == '0 && doutB == '0))
      else $error("global reset did not clear both outputs");

endmodule
`default_nettype wire

// file: testbench/fabric_port_model.sv
`timescale 1ns/1ps
`default_nettype none
module fabric_port_model
   import ram_block_pkg::*;
(
   input  wire logic             mclk, // clock
   output logic                  ce,   // port enable
   output logic                  we,   // write request
   output logic [ADDR_W-1:0]     addr, // word address
   output logic [WORD_BITS-1:0]  din,  // write data
   output logic [BYTES-1:0]      be    // byte enables
);
   initial
   begin
      ce = 1'b0;
      we = 1'b0;
      addr = '0;
      din = '0;
      be = '0;
   end
   // one request per call and one caller per port, so the two ports only
   // meet on one address when a test asks for it
   task automatic op(input logic w, input logic [ADDR_W-1:0] a,
      input logic [WORD_BITS-1:0] d, input logic [BYTES-1:0] b,
      input int n);
      ce <= 1'b1;
      we <= w;
      addr <= a;
      din <= d;
      be <= b;
      repeat (n) @(posedge mclk);
      ce <= 1'b0;
      we <= 1'b0;
      // released address and data lines show junk, not the last value
      addr <= ~a;
      din <= ~d;
   endtask
endmodule
`default_nettype wire

// file: testbench/tb_embedded_ram_block.sv
`timescale 1ns/1ps
`default_nettype none
module tb_embedded_ram_block;
   import ram_block_pkg::*;
   logic                 mclk, nrst, globalSetResetN, e;
   logic [APB_AW-1:0]    paddr;
   logic                 psel, penable, pwrite, pready, pslverr;
   logic [31:0]          pwdata, prdata, r;
   logic                 portAOutputReset, portBOutputReset;
   logic                 ceA, weA, ceB, weB;
   logic [ADDR_W-1:0]    addrA, addrB;
   logic [WORD_BITS-1:0] dinA, dinB, doutA, doutB;
   logic [BYTES-1:0]     beA, beB;
   int                   badCount, comparisons, cycles;

   embedded_ram_block i_dut (.mclk(mclk), .nrst(nrst),
      .globalSetResetN(globalSetResetN), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ceA(ceA), .weA(weA),
      .addrA(addrA), .dinA(dinA), .beA(beA),
      .portAOutputReset(portAOutputReset), .doutA(doutA), .ceB(ceB),
      .weB(weB), .addrB(addrB), .dinB(dinB), .beB(beB),
      .portBOutputReset(portBOutputReset), .doutB(doutB));
   fabric_port_model i_a (.mclk(mclk), .ce(ceA), .we(weA), .addr(addrA),
      .din(dinA), .be(beA));
   fabric_port_model i_b (.mclk(mclk), .ce(ceB), .we(weB), .addr(addrB),
      .din(dinB), .be(beB));

   always #2 mclk = ~mclk;

   task automatic summarize();
      $display("checks %0d mismatches %0d", comparisons, badCount);
      if (badCount == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   always @(posedge mclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         badCount++;
         $display("BAD %0t timeout", $time);
         summarize();
      end
   end

   task automatic chk(input logic [WORD_BITS-1:0] g, x);
      comparisons++;
      if (g !== x)
         $display("BAD %0t got %h want %h", $time, g, x);
      if (g !== x)
         badCount++;
   endtask

   // called just after a rising edge; one idle cycle follows each transfer
   task automatic apb(input logic w, input logic [APB_AW-1:0] a,
      input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // outputs are read here before this edge's updates land
      do @(posedge mclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic reg32(input logic [APB_AW-1:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk({4'h0, r}, {4'h0, x});
   endtask

   task automatic pt(input logic p, w, input logic [ADDR_W-1:0] a,
      input logic [WORD_BITS-1:0] d, input logic [BYTES-1:0] b,
      input int n, input logic [WORD_BITS-1:0] x);
      if (p)
         i_b.op(w, a, d, b, n);
      else
         i_a.op(w, a, d, b, n);
      // the second edge reads what the first one left on the output
      repeat (2) @(posedge mclk);
      chk(p ? doutB : doutA, x);
   endtask

   initial
   begin
      mclk = 1'b0;
      nrst = 1'b0;
      globalSetResetN = 1'b1;
      portAOutputReset = 1'b0;
      portBOutputReset = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      repeat (20) @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
      reg32(CTRL_OFS, {15'h0, CTRL_RESET});
      apb(1'b0, 8'h20, 32'h0);
      chk({35'h0, e}, 36'h1);
      apb(1'b1, CTRL_OFS, 32'h4014);
      reg32(CTRL_OFS, 32'h4014);
      pt(0, 1, 3, 36'h123456789, 4'hF, 1, 36'h0);
      pt(0, 0, 3, 36'h0, 4'h0, 1, 36'h123456789);
      pt(0, 1, 3, 36'hFFFFFFFFF, 4'h1, 1, 36'h123456789);
      pt(0, 0, 3, 36'h0, 4'h0, 1, 36'h1234567FF);
      apb(1'b1, CTRL_OFS, 32'h4114);
      pt(0, 1, 4, 36'h9ABCDEF01, 4'hF, 1, 36'h9ABCDEF01);
      apb(1'b1, CTRL_OFS, 32'h4214);
      pt(0, 1, 3, 36'h0AAAAAAAA, 4'hF, 1, 36'h1234567FF);
      apb(1'b1, CTRL_OFS, 32'h5014);
      // output register needs the enable at the second edge too
      pt(0, 0, 4, 36'h0, 4'h0, 1, 36'h1234567FF);
      pt(0, 0, 4, 36'h0, 4'h0, 3, 36'h9ABCDEF01);
      apb(1'b1, CTRL_OFS, 32'h4076);
      pt(1, 0, 12, 36'h0, 4'h0, 1, 36'h0AA);
      pt(1, 0, 13, 36'h0, 4'h0, 1, 36'h155);
      pt(1, 1, 13, 36'h1FF, 4'hF, 1, 36'h155);
      pt(0, 0, 3, 36'h0, 4'h0, 1, 36'h0AAAAAAAA);
      apb(1'b1, INIT_ADDR_OFS, 32'h5);
      apb(1'b1, INIT_HI_OFS, 32'hA);
      apb(1'b1, INIT_DATA_OFS, 32'h12345678);
      apb(1'b1, CTRL_OFS, 32'h4017);
      // a write in read-only mode turns into a plain read
      pt(0, 1, 5, 36'h0, 4'hF, 1, 36'hA12345678);
      pt(0, 0, 14'h0205, 36'h0, 4'h0, 1, 36'hA12345678);
      pt(1, 0, 14'h00B7, 36'h0, 4'h0, 1, 36'h1);
      portAOutputReset <= 1'b1;
      @(posedge mclk);
      chk(doutA, 36'h0);
      chk(doutB, 36'h1);
      portAOutputReset <= 1'b0;
      globalSetResetN <= 1'b0;
      @(posedge mclk);
      chk(doutB, 36'h0);
      globalSetResetN <= 1'b1;
      @(posedge mclk);
      // x36 asked in true dual-port runs as x18 and is flagged
      apb(1'b1, CTRL_OFS, 32'h4095);
      reg32(STATUS_OFS, 32'h1);
      // both ports on one word in one cycle: the conflict flag must latch
      fork
         i_a.op(1'b1, 14'h0001, 36'h2A5A5, 4'h3, 1);
         i_b.op(1'b0, 14'h0001, 36'h0, 4'h0, 1);
      join
      @(posedge mclk);
      reg32(STATUS_OFS, 32'h5);
      apb(1'b1, STATUS_OFS, 32'h4);
      reg32(STATUS_OFS, 32'h1);
      pt(1, 0, 1, 36'h0, 4'h0, 1, 36'h2A5A5);
      summarize();
   end
endmodule
`default_nettype wire
